// ===== inc/ppr_consts.svh
`ifndef PPR_CONSTS_SVH
`define PPR_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Device register offsets, as seen on the link address.
`define PPR_OFF_TX_SEL       12'h50a
`define PPR_OFF_PWR          12'h800
`define PPR_OFF_RST          12'h804
`define PPR_OFF_CLK          12'h808
`define PPR_OFF_STAT         12'h814

////////////////////////////////////////////////////////////////////////////////
// Unlock keys carried in the top byte of a protected write.
`define PPR_KEY_POS          24
`define PPR_KEY_PWR          8'h26
`define PPR_KEY_RST          8'hb1
`define PPR_KEY_CLK          8'ha9

////////////////////////////////////////////////////////////////////////////////
// Field positions and widths.
`define PPR_SEL_W            12
`define PPR_PWR_EN_BIT       0
`define PPR_RST_PULSE_BIT    0
`define PPR_RST_CLR_BIT      1
`define PPR_CLK_BLOCK_BIT    8
`define PPR_STAT_FLAG_BIT    16

////////////////////////////////////////////////////////////////////////////////
// Descriptor selector codes and reset values.
`define PPR_SEL_RESET        12'hfff
`define PPR_SEL_DED_MAX      12'h00f
`define PPR_SEL_SHR_MIN      12'h010
`define PPR_SEL_SHR_MAX      12'hffe
`define PPR_DED_SLOTS        16

////////////////////////////////////////////////////////////////////////////////
// Controller register word indices on the Avalon-MM slave (address bits [4:2]).
`define PPR_AV_CMD_ADDR      3'h0
`define PPR_AV_CMD_WDATA     3'h1
`define PPR_AV_CMD_CTRL      3'h2
`define PPR_AV_RDATA         3'h3
`define PPR_AV_IRQ_STAT      3'h4
`define PPR_AV_IRQ_MASK      3'h5
`define PPR_CTRL_GO_BIT      0
`define PPR_CTRL_WR_BIT      1
`define PPR_IRQ_DONE_BIT     0
`define PPR_IRQ_OVR_BIT      1

`endif

// ===== inc/ppr_pkg.sv
package ppr_pkg;

	// Controller sequencing of one link access.
	typedef enum logic [1:0] {
		PPR_ST_IDLE = 2'b00,
		PPR_ST_REQ  = 2'b01
	} ppr_state_t;

	// Link address and data types.
	typedef logic [11:0] ppr_addr_t;
	typedef logic [31:0] ppr_word_t;

endpackage

// ===== inc/ppr_link_if.sv
`timescale 1ns/1ns

// Register access link between the controller and the wrapper.
interface ppr_link_if;
	logic               req;    // Access request, held until ack.
	logic               wr;     // High for a write.
	ppr_pkg::ppr_addr_t addr;   // Device register offset.
	ppr_pkg::ppr_word_t wdata;  // Write data.
	logic               ack;    // One-cycle answer.
	ppr_pkg::ppr_word_t rdata;  // Read data, valid with ack.

	modport dev (input req, wr, addr, wdata, output ack, rdata);
	modport ctl (output req, wr, addr, wdata, input ack, rdata);
endinterface

// ===== rtl/ppr_key_gate.sv
`timescale 1ns/1ns
`include "ppr_consts.svh"

// Qualifies one protected register write by its address and unlock byte.
module ppr_key_gate #(
	parameter logic [11:0] OFFSET = 12'h000,
	parameter logic [7:0]  KEY    = 8'h00
) (
	// Access side.
	input  wire logic        wr_stb_in,
	input  wire logic [11:0] addr_in,
	input  wire logic [7:0]  key_in,
	// Result.
	output wire logic        hit_out,
	output wire logic        unlocked_out
);

	// Address match alone, used for reads and refused writes.
	assign hit_out = (addr_in == OFFSET);

	// A write with any other top byte is dropped silently.
	assign unlocked_out = wr_stb_in & hit_out & (key_in == KEY);

endmodule // ppr_key_gate

// ===== rtl/ppr_wrapper_dev.sv
// Notes on behaviour
// R1: 12-bit selector resets FFFh, FFFh routes nothing.
// R2: Selector 0h-Fh routes to dedicated slot.
// R3: 10h-FFEh routes shared entry, extended mode only.
// R4: Trigger reaches only the selected descriptor.
// R5: Power bit written only with key 26h.
// R6: Power bit drives power, resets 0, readable.
// R7: Power key byte is write-only, never stored.
// R8: Bit0 with key B1h pulses peripheral reset.
// R9: Bit1 with key B1h clears reset flag.
// R10: Reset-control fields write-only one-shot commands.
// R11: Clock config changes only with key A9h.
// R12: Block bit stops async clock requests, resets 0.
// R13: Sticky flag bit16 set on peripheral reset.
// R14: Wrong key writes ignored silently, fields unchanged.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns
`include "ppr_consts.svh"

module ppr_wrapper_dev (
	// Clock and reset.
	input  wire logic                        CLK_SYS_IN,
	input  wire logic                        RST_N_IN,
	// Register access link.
	ppr_link_if.dev                          LINK,
	// Peripheral side.
	input  wire logic                        TX_TRIG_IN,
	input  wire logic                        ASYNC_REQ_IN,
	// System side.
	input  wire logic                        EXT_DESC_MODE_IN,
	// DMA side.
	output logic [`PPR_DED_SLOTS-1:0]        DED_SLOT_TRIG_OUT,
	output logic                             SHARED_TRIG_OUT,
	output logic [`PPR_SEL_W-1:0]            SHARED_INDEX_OUT,
	// Clock and power controller side.
	output logic                             POWER_EN_OUT,
	output logic                             PERIPH_RST_OUT,
	output logic                             ASYNC_REQ_OUT
);

	////////////////////////////////////////////////////////////////////////////
	// Access decode.

	logic                   ack_q;             // Answer flop.
	logic [31:0]            rdata_q;           // Read data flop.
	logic [`PPR_SEL_W-1:0]  sel_q;             // Descriptor selector.
	logic                   pwr_q;             // Power enable.
	logic                   block_q;           // Async request block.
	logic                   flag_q;            // Reset-occurred flag.
	logic                   rst_pulse_q;       // One-cycle reset pulse.
	logic [`PPR_DED_SLOTS-1:0] ded_q;          // Dedicated slot strobes.
	logic                   shr_q;             // Shared entry strobe.
	logic [`PPR_SEL_W-1:0]  shr_idx_q;         // Shared entry index.
	logic                   async_q;           // Gated async request.

	wire        acc_stb = LINK.req & ~ack_q;   // First cycle of an access.
	wire        wr_stb  = acc_stb & LINK.wr;   // Write taking effect now.
	wire [7:0]  key     = LINK.wdata[31:24];   // Top byte of the write.
	wire        hit_sel  = (LINK.addr == `PPR_OFF_TX_SEL);
	wire        hit_stat = (LINK.addr == `PPR_OFF_STAT);
	wire        hit_pwr;
	wire        hit_clk;
	wire        wr_pwr;
	wire        wr_rst;
	wire        wr_clk;
	wire        wr_sel   = wr_stb & hit_sel;

	// R5 key 26h gate
	// R14 wrong key dropped
	ppr_key_gate #(
		.OFFSET (`PPR_OFF_PWR),
		.KEY    (`PPR_KEY_PWR)
	) u_gate_pwr (
		.wr_stb_in    (wr_stb),
		.addr_in      (LINK.addr),
		.key_in       (key),
		.hit_out      (hit_pwr),
		.unlocked_out (wr_pwr)
	);

	// R8 key B1h gate
	ppr_key_gate #(
		.OFFSET (`PPR_OFF_RST),
		.KEY    (`PPR_KEY_RST)
	) u_gate_rst (
		.wr_stb_in    (wr_stb),
		.addr_in      (LINK.addr),
		.key_in       (key),
		.hit_out      (),
		.unlocked_out (wr_rst)
	);

	// R11 key A9h gate
	ppr_key_gate #(
		.OFFSET (`PPR_OFF_CLK),
		.KEY    (`PPR_KEY_CLK)
	) u_gate_clk (
		.wr_stb_in    (wr_stb),
		.addr_in      (LINK.addr),
		.key_in       (key),
		.hit_out      (hit_clk),
		.unlocked_out (wr_clk)
	);

	// R8 assert reset command
	wire cmd_pulse = wr_rst & LINK.wdata[`PPR_RST_PULSE_BIT];
	// R9 flag clear command
	wire cmd_clear = wr_rst & LINK.wdata[`PPR_RST_CLR_BIT];

	////////////////////////////////////////////////////////////////////////////
	// Read mux.

	// R7 key never read back
	// R10 reset-control reads zero
	wire [31:0] rd_pwr  = {31'h0000_0000, pwr_q};
	wire [31:0] rd_sel  = {20'h0_0000, sel_q};
	wire [31:0] rd_clk  = {23'h00_0000, block_q, 8'h00};
	wire [31:0] rd_stat = {15'h0000, flag_q, 16'h0000};
	wire [31:0] rd_mux  = hit_sel  ? rd_sel  :
	                      hit_pwr  ? rd_pwr  :
	                      hit_clk  ? rd_clk  :
	                      hit_stat ? rd_stat : 32'h0000_0000;

	// Answer one cycle after the request; ack low again before a new access.
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q   <= acc_stb;
			rdata_q <= acc_stb ? rd_mux : rdata_q;
		end
	end

	assign LINK.ack   = ack_q;
	assign LINK.rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Stored fields.

	// R1 selector with reset FFFh
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			sel_q <= `PPR_SEL_RESET;
		else if (wr_sel)
			sel_q <= LINK.wdata[`PPR_SEL_W-1:0];
	end

	// R6 power bit storage
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			pwr_q <= 1'b0;
		else if (wr_pwr)
			pwr_q <= LINK.wdata[`PPR_PWR_EN_BIT];
	end

	// R12 block bit storage
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			block_q <= 1'b0;
		else if (wr_clk)
			block_q <= LINK.wdata[`PPR_CLK_BLOCK_BIT];
	end

	////////////////////////////////////////////////////////////////////////////
	// Reset command and sticky flag.

	// R10 one-shot reset pulse
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			rst_pulse_q <= 1'b0;
		else
			rst_pulse_q <= cmd_pulse;
	end

	// R13 sticky flag, set wins
	// The set wins so a reset issued with the clear in one write is not lost.
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			flag_q <= 1'b0;
		else if (cmd_pulse)
			flag_q <= 1'b1;
		else if (cmd_clear)
			flag_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Trigger routing.

	wire sel_ded = (sel_q <= `PPR_SEL_DED_MAX);
	// R3 shared range and mode
	wire sel_shr = (sel_q >= `PPR_SEL_SHR_MIN) & (sel_q <= `PPR_SEL_SHR_MAX) & EXT_DESC_MODE_IN;

	// R2 dedicated slot strobe
	// R4 only selected slot
	// R1 FFFh routes nothing
	// The strobe is rebuilt each cycle so no stale slot can stay asserted.
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			ded_q     <= '0;
			shr_q     <= 1'b0;
			shr_idx_q <= `PPR_SEL_RESET;
		end
		else
		begin
			ded_q     <= (TX_TRIG_IN & sel_ded) ? (16'h0001 << sel_q[3:0]) : 16'h0000;
			shr_q     <= TX_TRIG_IN & sel_shr;
			shr_idx_q <= (TX_TRIG_IN & sel_shr) ? sel_q : shr_idx_q;
		end
	end

	// R12 async request gate
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			async_q <= 1'b0;
		else
			async_q <= ASYNC_REQ_IN & ~block_q;
	end

	// R6 power follows bit
	assign POWER_EN_OUT      = pwr_q;
	assign PERIPH_RST_OUT    = rst_pulse_q;
	assign ASYNC_REQ_OUT     = async_q;
	assign DED_SLOT_TRIG_OUT = ded_q;
	assign SHARED_TRIG_OUT   = shr_q;
	assign SHARED_INDEX_OUT  = shr_idx_q;

endmodule // ppr_wrapper_dev

// ===== rtl/ppr_link_ctl.sv
`timescale 1ns/1ns
`include "ppr_consts.svh"

// Software-facing controller: takes link accesses as commands over Avalon-MM.
module ppr_link_ctl (
	// Clock and reset.
	input  wire logic        CLK_SYS_IN,
	input  wire logic        RST_N_IN,
	// Avalon-MM slave.
	input  wire logic [4:0]  AVS_ADDRESS_IN,
	input  wire logic        AVS_READ_IN,
	input  wire logic        AVS_WRITE_IN,
	input  wire logic [31:0] AVS_WRITEDATA_IN,
	output logic [31:0]      AVS_READDATA_OUT,
	output logic             AVS_WAITREQUEST_OUT,
	// Interrupt.
	output logic             IRQ_OUT,
	// Register access link.
	ppr_link_if.ctl          LINK
);

	////////////////////////////////////////////////////////////////////////////
	// Avalon slave timing: one wait state, the access completes when waitrequest drops.

	logic                 wait_q;      // Waitrequest flop, high when idle.
	logic [31:0]          av_rd_q;     // Avalon read data.
	logic [11:0]          cmd_addr_q;  // Link address for the next access.
	logic [31:0]          cmd_wdata_q; // Link write data.
	logic                 cmd_wr_q;    // Direction of the pending access.
	logic [31:0]          link_rd_q;   // Last link read data.
	logic [1:0]           irq_stat_q;  // Sticky events.
	logic [1:0]           irq_mask_q;  // Event enables.
	logic                 irq_q;       // Interrupt flop.
	ppr_pkg::ppr_state_t  st_q;        // Access sequencer.

	wire       av_req  = AVS_READ_IN | AVS_WRITE_IN;
	wire       av_done = av_req & ~wait_q;          // Edge at which the access completes.
	wire       av_wr   = av_done & AVS_WRITE_IN;
	wire [2:0] widx    = AVS_ADDRESS_IN[4:2];
	wire       busy    = (st_q == ppr_pkg::PPR_ST_REQ);
	wire       go      = av_wr & (widx == `PPR_AV_CMD_CTRL) & AVS_WRITEDATA_IN[`PPR_CTRL_GO_BIT];
	wire       start   = go & ~busy;
	wire       done    = busy & LINK.ack;
	wire       clr_wr  = av_wr & (widx == `PPR_AV_IRQ_STAT);
	wire [1:0] ev      = {go & busy, done};

	wire [31:0] rd_mux = (widx == `PPR_AV_CMD_ADDR)  ? {20'h0_0000, cmd_addr_q} :
	                     (widx == `PPR_AV_CMD_WDATA) ? cmd_wdata_q :
	                     (widx == `PPR_AV_CMD_CTRL)  ? {30'h0000_0000, cmd_wr_q, busy} :
	                     (widx == `PPR_AV_RDATA)     ? link_rd_q :
	                     (widx == `PPR_AV_IRQ_STAT)  ? {30'h0000_0000, irq_stat_q} :
	                     (widx == `PPR_AV_IRQ_MASK)  ? {30'h0000_0000, irq_mask_q} : 32'h0000_0000;

	// Waitrequest drops for exactly the completing cycle, then rises again.
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			wait_q  <= 1'b1;
			av_rd_q <= 32'h0000_0000;
		end
		else
		begin
			wait_q  <= ~(av_req & wait_q);
			av_rd_q <= (av_req & wait_q) ? rd_mux : av_rd_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command registers; address and data are frozen while an access runs.

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			cmd_addr_q  <= 12'h000;
			cmd_wdata_q <= 32'h0000_0000;
			cmd_wr_q    <= 1'b0;
			irq_mask_q  <= 2'h0;
		end
		else
		begin
			if (av_wr & ~busy & (widx == `PPR_AV_CMD_ADDR))
				cmd_addr_q <= AVS_WRITEDATA_IN[11:0];
			if (av_wr & ~busy & (widx == `PPR_AV_CMD_WDATA))
				cmd_wdata_q <= AVS_WRITEDATA_IN;
			if (start)
				cmd_wr_q <= AVS_WRITEDATA_IN[`PPR_CTRL_WR_BIT];
			if (av_wr & (widx == `PPR_AV_IRQ_MASK))
				irq_mask_q <= AVS_WRITEDATA_IN[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link sequencer: request held until the one-cycle ack.

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			st_q      <= ppr_pkg::PPR_ST_IDLE;
			link_rd_q <= 32'h0000_0000;
		end
		else
		begin
			unique case (st_q)
				ppr_pkg::PPR_ST_IDLE:
					st_q <= start ? ppr_pkg::PPR_ST_REQ : ppr_pkg::PPR_ST_IDLE;
				ppr_pkg::PPR_ST_REQ:
					st_q <= LINK.ack ? ppr_pkg::PPR_ST_IDLE : ppr_pkg::PPR_ST_REQ;
			endcase
			if (done & ~cmd_wr_q)
				link_rd_q <= LINK.rdata;
		end
	end

	// Sticky events: a new event wins over a write-one clear in the same cycle.
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			irq_stat_q <= 2'h0;
			irq_q      <= 1'b0;
		end
		else
		begin
			irq_stat_q <= (irq_stat_q & ~(clr_wr ? AVS_WRITEDATA_IN[1:0] : 2'h0)) | ev;
			irq_q      <= |(((irq_stat_q & ~(clr_wr ? AVS_WRITEDATA_IN[1:0] : 2'h0)) | ev) & irq_mask_q);
		end
	end

	assign AVS_READDATA_OUT    = av_rd_q;
	assign AVS_WAITREQUEST_OUT = wait_q;
	assign IRQ_OUT             = irq_q;
	assign LINK.req            = busy;
	assign LINK.wr             = cmd_wr_q;
	assign LINK.addr           = cmd_addr_q;
	assign LINK.wdata          = cmd_wdata_q;

endmodule // ppr_link_ctl

// ===== verif/ppr_link_checker.sv
`timescale 1ns/1ns
`include "ppr_consts.svh"

// Watches the link between the controller and the wrapper, and the wrapper's far side.
module ppr_link_checker (
	// Clock and reset.
	input  wire logic               CLK_SYS_IN,
	input  wire logic               RST_N_IN,
	// Link signals.
	input  wire logic               req,
	input  wire logic               wr,
	input  wire ppr_pkg::ppr_addr_t addr,
	input  wire ppr_pkg::ppr_word_t wdata,
	input  wire logic               ack,
	input  wire ppr_pkg::ppr_word_t rdata,
	// Wrapper far side.
	input  wire logic               TX_TRIG_IN,
	input  wire logic               ASYNC_REQ_IN,
	input  wire logic               EXT_DESC_MODE_IN,
	input  wire logic [15:0]        DED_SLOT_TRIG_OUT,
	input  wire logic               SHARED_TRIG_OUT,
	input  wire logic [11:0]        SHARED_INDEX_OUT,
	input  wire logic               POWER_EN_OUT,
	input  wire logic               PERIPH_RST_OUT,
	input  wire logic               ASYNC_REQ_OUT
);
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_N_IN);

	////////////////////////////////////////////////////////////////////////////////
	// A write that the device takes, at a given offset with a given key.
	sequence s_take(off, key);
		req && !ack && wr && addr == off && wdata[31:24] == key;
	endsequence

	// One answer per request, exactly one cycle after it rises.
	property p_ack_once;
		$rose(req) |=> ack ##1 !ack;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("link ack late or long");

	// The request and its data stay still until answered.
	property p_hold;
		req && !ack |=> req && $stable(addr) && $stable(wdata);
	endproperty
	a_hold: assert property (p_hold) else $error("link request moved before ack");

	// The power bit moves only on a keyed power write.
	property p_pwr_key;
		$changed(POWER_EN_OUT) |-> $past(req && !ack && wr && addr == `PPR_OFF_PWR && wdata[31:24] == `PPR_KEY_PWR);
	endproperty
	a_pwr_key: assert property (p_pwr_key) else $error("power changed without key");

	// A keyed power write sets the output to the written bit.
	property p_pwr_set;
		s_take(`PPR_OFF_PWR, `PPR_KEY_PWR) |=> POWER_EN_OUT == $past(wdata[0]);
	endproperty
	a_pwr_set: assert property (p_pwr_set) else $error("power bit not applied");

	// Power reads show only the enable bit, never the key.
	property p_pwr_rd;
		$past(req && !ack && !wr && addr == `PPR_OFF_PWR) |-> ack && rdata[31:1] == 31'h0;
	endproperty
	a_pwr_rd: assert property (p_pwr_rd) else $error("power read shows stored key");

	// A keyed reset command gives a one-cycle reset pulse.
	property p_rst_cmd;
		s_take(`PPR_OFF_RST, `PPR_KEY_RST) ##0 wdata[0] |=> PERIPH_RST_OUT ##1 !PERIPH_RST_OUT;
	endproperty
	a_rst_cmd: assert property (p_rst_cmd) else $error("reset pulse missing");

	// No reset pulse without a keyed command carrying bit 0.
	property p_rst_cause;
		$rose(PERIPH_RST_OUT) |-> $past(req && !ack && wr && addr == `PPR_OFF_RST && wdata[31:24] == `PPR_KEY_RST && wdata[0]);
	endproperty
	a_rst_cause: assert property (p_rst_cause) else $error("reset pulse without command");

	// Two cycles after a keyed write sets the block bit, no request passes.
	property p_block;
		s_take(`PPR_OFF_CLK, `PPR_KEY_CLK) ##0 wdata[8] |-> ##2 !ASYNC_REQ_OUT;
	endproperty
	a_block: assert property (p_block) else $error("async request passed while blocked");

	// A passed request has a cause at the peripheral.
	property p_async_src;
		ASYNC_REQ_OUT |-> $past(ASYNC_REQ_IN);
	endproperty
	a_async_src: assert property (p_async_src) else $error("async request from nowhere");

	// A dedicated strobe is one-hot, alone, and caused by a trigger.
	property p_ded;
		|DED_SLOT_TRIG_OUT |-> $onehot(DED_SLOT_TRIG_OUT) && !SHARED_TRIG_OUT && $past(TX_TRIG_IN);
	endproperty
	a_ded: assert property (p_ded) else $error("dedicated strobe wrong");

	// A shared strobe needs extended mode and a shared index.
	property p_shared;
		SHARED_TRIG_OUT |-> $past(TX_TRIG_IN && EXT_DESC_MODE_IN) && SHARED_INDEX_OUT inside {[12'h010:12'hffe]};
	endproperty
	a_shared: assert property (p_shared) else $error("shared strobe wrong");
endmodule // ppr_link_checker

// ===== verif/periph_power_reset_clock_ctrl_tb.sv
`timescale 1ns/1ns
`include "ppr_consts.svh"

module periph_power_reset_clock_ctrl_tb;
	logic        clk_sys, rst_n, av_rd, av_wr, tx_trig, async_req, ext_mode;
	logic [4:0]  av_addr;
	logic [31:0] av_wdata, rd;
	wire  [31:0] av_rdata;
	wire         av_wait, irq, shr_trig, pwr_en, per_rst, async_out;
	wire  [15:0] ded_trig;
	wire  [11:0] shr_idx;
	int          n_fail, cmp_count;
	int          n_rst = 0;  // Cycles in which the peripheral reset was seen high.
	logic [11:0] sel_t [5] = '{12'h000, 12'h00f, 12'h010, 12'hffe, 12'h010};

	ppr_link_if link_inst ();
	ppr_link_ctl ppr_link_ctl_inst (.CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(av_addr),
		.AVS_READ_IN(av_rd), .AVS_WRITE_IN(av_wr), .AVS_WRITEDATA_IN(av_wdata), .AVS_READDATA_OUT(av_rdata),
		.AVS_WAITREQUEST_OUT(av_wait), .IRQ_OUT(irq), .LINK(link_inst));
	ppr_wrapper_dev ppr_wrapper_dev_inst (.CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n), .LINK(link_inst),
		.TX_TRIG_IN(tx_trig), .ASYNC_REQ_IN(async_req), .EXT_DESC_MODE_IN(ext_mode), .DED_SLOT_TRIG_OUT(ded_trig),
		.SHARED_TRIG_OUT(shr_trig), .SHARED_INDEX_OUT(shr_idx), .POWER_EN_OUT(pwr_en), .PERIPH_RST_OUT(per_rst),
		.ASYNC_REQ_OUT(async_out));
	ppr_link_checker ppr_link_checker_inst (.CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n), .req(link_inst.req),
		.wr(link_inst.wr), .addr(link_inst.addr), .wdata(link_inst.wdata), .ack(link_inst.ack),
		.rdata(link_inst.rdata), .TX_TRIG_IN(tx_trig), .ASYNC_REQ_IN(async_req), .EXT_DESC_MODE_IN(ext_mode),
		.DED_SLOT_TRIG_OUT(ded_trig), .SHARED_TRIG_OUT(shr_trig), .SHARED_INDEX_OUT(shr_idx),
		.POWER_EN_OUT(pwr_en), .PERIPH_RST_OUT(per_rst), .ASYNC_REQ_OUT(async_out));

	// Counts reset pulse cycles, so both a missing and a stretched pulse show up in a compare.
	always @(posedge clk_sys)
	begin
		if (per_rst === 1'b1)
			n_rst <= n_rst + 1;
	end

	// Prints the verdict and stops the run.
	task automatic complete_run();
		if (n_fail == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One Avalon access; the request is held until a rising edge sees waitrequest low.
	// Read data is taken at that same edge, and only then is the request released.
	task automatic av_xfer(input logic w, input logic [2:0] idx, input logic [31:0] d, output logic [31:0] q);
		int  i;
		logic ok;
		av_addr <= {idx, 2'b00};
		av_wr <= w;
		av_rd <= !w;
		av_wdata <= d;
		ok = 1'b0;
		q = 32'h0000_0000;
		i = 0;
		while (!ok && i < 50)
		begin
			@(posedge clk_sys);
			ok = (av_wait === 1'b0);
			q = av_rdata;
			i++;
		end
		av_wr <= 1'b0;
		av_rd <= 1'b0;
		@(posedge clk_sys);
		if (!ok)
		begin
			n_fail++;
			complete_run();
		end
	endtask

	// One device access through the controller; waits for done and clears it.
	task automatic dev(input logic w, input logic [11:0] off, input logic [31:0] d, output logic [31:0] q);
		int i;
		av_xfer(1'b1, `PPR_AV_CMD_ADDR, {20'h0, off}, q);
		av_xfer(1'b1, `PPR_AV_CMD_WDATA, d, q);
		av_xfer(1'b1, `PPR_AV_CMD_CTRL, {30'h0, w, 1'b1}, q);
		i = 0;
		do
		begin
			av_xfer(1'b0, `PPR_AV_IRQ_STAT, 32'h0, q);
			i++;
		end
		while (q[0] !== 1'b1 && i < 20);
		if (q[0] !== 1'b1)
		begin
			n_fail++;
			complete_run();
		end
		av_xfer(1'b1, `PPR_AV_IRQ_STAT, 32'h1, q);
		av_xfer(1'b0, `PPR_AV_RDATA, 32'h0, q);
	endtask

	// One trigger strobe, then a look at the routed outputs.
	task automatic trig(input logic [15:0] ed, input logic es);
		tx_trig <= 1'b1;
		@(posedge clk_sys);
		tx_trig <= 1'b0;
		@(negedge clk_sys);
		check({15'h0, shr_trig, ded_trig}, {15'h0, es, ed});
		@(posedge clk_sys);
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	initial
	begin
		{rst_n, av_rd, av_wr, tx_trig, async_req, ext_mode, av_addr, av_wdata} = '0;
		n_fail = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		dev(1'b0, `PPR_OFF_TX_SEL, 32'h0, rd);
		check(rd, 32'h00000fff);
		trig(16'h0, 1'b0);
		// Every routing class, shared once without extended mode.
		for (int k = 0; k < 5; k++)
		begin
			ext_mode <= (k != 4);
			dev(1'b1, `PPR_OFF_TX_SEL, {20'h0, sel_t[k]}, rd);
			trig((sel_t[k] < 12'h010) ? (16'h1 << sel_t[k]) : 16'h0, k == 2 || k == 3);
		end
		check({20'h0, shr_idx}, 32'h00000ffe);
		check({31'h0, pwr_en}, 32'h0);
		dev(1'b1, `PPR_OFF_PWR, 32'h00000001, rd);
		dev(1'b0, `PPR_OFF_PWR, 32'h0, rd);
		check(rd, 32'h0);
		dev(1'b1, `PPR_OFF_PWR, 32'h26000001, rd);
		dev(1'b0, `PPR_OFF_PWR, 32'h0, rd);
		check(rd, 32'h1);
		check({31'h0, pwr_en}, 32'h1);
		dev(1'b1, `PPR_OFF_RST, 32'h00000001, rd);
		dev(1'b1, `PPR_OFF_RST, 32'hb1000001, rd);
		check(n_rst, 32'h1);
		dev(1'b0, `PPR_OFF_STAT, 32'h0, rd);
		check(rd, 32'h00010000);
		dev(1'b0, `PPR_OFF_RST, 32'h0, rd);
		check(rd, 32'h0);
		dev(1'b1, `PPR_OFF_RST, 32'hb1000000, rd);
		check(n_rst, 32'h1);
		dev(1'b1, `PPR_OFF_RST, 32'h00000002, rd);
		dev(1'b0, `PPR_OFF_STAT, 32'h0, rd);
		check(rd, 32'h00010000);
		dev(1'b1, `PPR_OFF_RST, 32'hb1000002, rd);
		dev(1'b0, `PPR_OFF_STAT, 32'h0, rd);
		check(rd, 32'h0);
		async_req <= 1'b1;
		dev(1'b1, `PPR_OFF_CLK, 32'h00000100, rd);
		check({31'h0, async_out}, 32'h1);
		dev(1'b1, `PPR_OFF_CLK, 32'ha9000100, rd);
		dev(1'b0, `PPR_OFF_CLK, 32'h0, rd);
		check(rd, 32'h00000100);
		check({31'h0, async_out}, 32'h0);
		// Done event masked, then unmasked, then cleared.
		av_xfer(1'b1, `PPR_AV_CMD_CTRL, 32'h1, rd);
		repeat (4) @(posedge clk_sys);
		check({31'h0, irq}, 32'h0);
		av_xfer(1'b1, `PPR_AV_IRQ_MASK, 32'h1, rd);
		repeat (2) @(posedge clk_sys);
		check({31'h0, irq}, 32'h1);
		av_xfer(1'b1, `PPR_AV_IRQ_STAT, 32'h1, rd);
		repeat (2) @(posedge clk_sys);
		check({31'h0, irq}, 32'h0);
		av_xfer(1'b0, 3'h7, 32'h0, rd);
		check(rd, 32'h0);
		complete_run();
	end
endmodule // periph_power_reset_clock_ctrl_tb
